// ==== rtl/ldgs_pkg.sv ====
/*
 Shared constants and types for the LED dimming gate and sleep control.
 Assumes a single 20 MHz system clock; all timing derives from it.
*/
`default_nettype none

package ldgs_pkg;

	// ----------------------------------------
	// Clock and time base
	// ----------------------------------------
	localparam int CLK_HZ       = 20_000_000;
	localparam int US_PER_S     = 1_000_000;
	localparam int US_TICK_CYC  = (CLK_HZ + US_PER_S - 1) / US_PER_S;

	// ----------------------------------------
	// Disable times before sleep, in microseconds
	// ----------------------------------------
	localparam int INT_DIM_DISABLE_TIME_US = 14_500;
	localparam int EXT_DIM_DISABLE_TIME_US = 29_000;
	localparam int DIS_CNT_W               = 16;

	// ----------------------------------------
	// Switching oscillator
	// ----------------------------------------
	localparam int OSC_FREQ_HZ  = 350_000;
	localparam int OSC_CYC      = CLK_HZ / OSC_FREQ_HZ;

	// ----------------------------------------
	// Internal PWM generator and external-signal detect
	// ----------------------------------------
	localparam int        DUTY_W        = 8;
	localparam logic [7:0] DUTY_TIE_CODE = 8'hFF;
	localparam int        PWM_STEP_US   = 20;
	localparam int        EXT_SEEN_US   = 20_000;

	// ----------------------------------------
	// Current sense, demand and soft-start reference
	// ----------------------------------------
	localparam int         SEN_W        = 10;
	localparam logic [9:0] REF_ZERO     = 10'h000;
	localparam logic [9:0] REF_ONE_VOLT = 10'h3FF;
	localparam logic [9:0] REF_STEP     = 10'h001;
	localparam int         SS_STEP_US   = 1;

	// ----------------------------------------
	// Operating states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_SLEEP = 2'b00,
		ST_SOFT  = 2'b01,
		ST_RUN   = 2'b10
	} ldgs_state_t;

	typedef struct packed {
		logic                 dim_s1;
		logic                 dim_s2;
		logic                 dim_s3;
		ldgs_state_t          st;
		logic                 latch;
		logic [DIS_CNT_W-1:0] dis_cnt;
		logic [DIS_CNT_W-1:0] ext_cnt;
		logic [DUTY_W-1:0]    pwm_ph;
		logic [SEN_W-1:0]     ramp;
		logic                 sw_gate;
		logic                 load_on;
		logic                 comp_hold;
		logic                 sleep;
	} ldgs_regs_t;

endpackage : ldgs_pkg

`default_nettype wire

// ==== rtl/ldgs_pulse_div.sv ====
/*
 Enable-pulse divider: one-cycle pulse every DIV enabled clocks.
 Assumes the same clock and reset as its user; en_i is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module ldgs_pulse_div #(
	parameter int DIV = 2
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic en_i,
	// Pulse out
	output logic      pulse_o
);

	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] ZERO = '0;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          pulse;
	} ldgs_div_t;

	ldgs_div_t s_ff;
	ldgs_div_t nxt_s;

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.pulse = 1'b0;
		if (en_i)
		begin
			if (s_ff.cnt == LAST)
			begin
				nxt_s.cnt   = ZERO;
				nxt_s.pulse = 1'b1;
			end
			else
			begin
				nxt_s.cnt = s_ff.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign pulse_o = s_ff.pulse;

endmodule : ldgs_pulse_div

`default_nettype wire

// ==== rtl/ldgs_top.sv ====
/*
 Dimming gate, switch latch, sleep timer and soft-start ramp of an LED
 converter controller. Assumes sense and demand codes and the hiccup
 request come from logic on MCLK_I; the dim-control pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module ldgs_top
	import ldgs_pkg::*;
#(
	parameter int P_INT_DIS_US  = INT_DIM_DISABLE_TIME_US,
	parameter int P_EXT_DIS_US  = EXT_DIM_DISABLE_TIME_US,
	parameter int P_EXT_SEEN_US = EXT_SEEN_US,
	parameter int P_US_CYC      = US_TICK_CYC,
	parameter int P_OSC_CYC     = OSC_CYC,
	parameter int P_PWM_STEP_US = PWM_STEP_US,
	parameter int P_SS_STEP_US  = SS_STEP_US
) (
	// Clock and reset
	input  wire logic              MCLK_I,
	input  wire logic              SYS_RST_I,
	// Dim control pin and duty setting
	input  wire logic              DIM_CONTROL_INPUT_I,
	input  wire logic [DUTY_W-1:0] DUTY_SET_INPUT_I,
	// Current loop
	input  wire logic [SEN_W-1:0]  SENSE_I,
	input  wire logic [SEN_W-1:0]  DEMAND_I,
	input  wire logic              HICCUP_I,
	// Drives
	output logic                   SWITCH_GATE_DRIVE_O,
	output logic                   LOAD_SWITCH_DRIVE_O,
	output logic                   COMP_HOLD_O,
	output logic                   SLEEP_O,
	output logic [SEN_W-1:0]       CURRENT_REFERENCE_O
);

	// ----------------------------------------
	// Limits at counter width
	// ----------------------------------------
	localparam logic [DIS_CNT_W-1:0] LIM_INT  = DIS_CNT_W'(P_INT_DIS_US);
	localparam logic [DIS_CNT_W-1:0] LIM_EXT  = DIS_CNT_W'(P_EXT_DIS_US);
	localparam logic [DIS_CNT_W-1:0] LIM_SEEN = DIS_CNT_W'(P_EXT_SEEN_US);
	localparam logic [DIS_CNT_W-1:0] CNT_ONE  = DIS_CNT_W'(1);
	localparam logic [DIS_CNT_W-1:0] CNT_ZERO = '0;

	// ----------------------------------------
	// Time bases
	// ----------------------------------------
	logic osc_tick;
	logic us_tick;
	logic pwm_tick;
	logic ss_tick;

	ldgs_pulse_div #(.DIV(P_OSC_CYC)) u_osc (
		.clk_i   (MCLK_I),
		.rst_i   (SYS_RST_I),
		.en_i    (1'b1),
		.pulse_o (osc_tick)
	);

	ldgs_pulse_div #(.DIV(P_US_CYC)) u_us (
		.clk_i   (MCLK_I),
		.rst_i   (SYS_RST_I),
		.en_i    (1'b1),
		.pulse_o (us_tick)
	);

	// Slow rates count microsecond ticks to keep the dividers small
	ldgs_pulse_div #(.DIV(P_PWM_STEP_US)) u_pwm (
		.clk_i   (MCLK_I),
		.rst_i   (SYS_RST_I),
		.en_i    (us_tick),
		.pulse_o (pwm_tick)
	);

	ldgs_pulse_div #(.DIV(P_SS_STEP_US)) u_ss (
		.clk_i   (MCLK_I),
		.rst_i   (SYS_RST_I),
		.en_i    (us_tick),
		.pulse_o (ss_tick)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ldgs_regs_t s_ff;
	ldgs_regs_t nxt_s;

	logic                 dim_hi;
	logic                 dim_edge;
	logic                 ext_seen;
	logic                 int_sel;
	logic                 int_act;
	logic                 pwm_on;
	logic                 gate;
	logic                 awake;
	logic                 sw_en;
	logic                 hit;
	logic [SEN_W-1:0]     demand_eff;
	logic [DIS_CNT_W-1:0] dis_lim;

	always_comb
	begin
		nxt_s = s_ff;
		// Two-stage sync; the second stage and its one-cycle delayed copy (dim_s3) feed logic
		nxt_s.dim_s1 = DIM_CONTROL_INPUT_I;
		nxt_s.dim_s2 = s_ff.dim_s1;
		nxt_s.dim_s3 = s_ff.dim_s2;
		dim_hi   = s_ff.dim_s2;
		// Edges while asleep are ignored: sync flops leave reset low under an idle high pin,
		// which would otherwise fake an external signal after every reset or wake-up
		dim_edge = (s_ff.st != ST_SLEEP) && (s_ff.dim_s2 ^ s_ff.dim_s3);

		// External signal detect: any pin edge while awake marks it present for a window
		if (dim_edge)
			nxt_s.ext_cnt = LIM_SEEN;
		else if (us_tick && (s_ff.ext_cnt != CNT_ZERO))
			nxt_s.ext_cnt = s_ff.ext_cnt - CNT_ONE;
		ext_seen = (s_ff.ext_cnt != CNT_ZERO);

		// Duty-set tied high means the internal generator is unused
		int_sel = (DUTY_SET_INPUT_I != DUTY_TIE_CODE);
		int_act = int_sel && !ext_seen;

		if (pwm_tick)
			nxt_s.pwm_ph = s_ff.pwm_ph + DUTY_W'(1);
		pwm_on = (s_ff.pwm_ph < DUTY_SET_INPUT_I);

		// Same gate path for either dimming source
		gate = dim_hi && (!int_act || pwm_on);

		dis_lim = int_sel ? LIM_INT : LIM_EXT;

		// Sleep-entry timer
		if (dim_hi)
			nxt_s.dis_cnt = CNT_ZERO;
		else if (us_tick && (s_ff.dis_cnt < dis_lim))
			nxt_s.dis_cnt = s_ff.dis_cnt + CNT_ONE;

		case (s_ff.st)
			ST_SLEEP:
			begin
				nxt_s.ramp = REF_ZERO;
				if (dim_hi)
					nxt_s.st = ST_SOFT;
			end
			ST_SOFT, ST_RUN:
			begin
				// At or past the limit, so a mode change while low still ends in sleep
				if (!dim_hi && us_tick && (s_ff.dis_cnt >= dis_lim - CNT_ONE))
				begin
					nxt_s.st   = ST_SLEEP;
					nxt_s.ramp = REF_ZERO;
				end
				else if (HICCUP_I)
				begin
					// Reference discharged for the whole hiccup
					nxt_s.st   = ST_SOFT;
					nxt_s.ramp = REF_ZERO;
				end
				else if (s_ff.st == ST_SOFT)
				begin
					if (s_ff.ramp == REF_ONE_VOLT)
						nxt_s.st = ST_RUN;
					else if (ss_tick)
						nxt_s.ramp = s_ff.ramp + REF_STEP;
				end
			end
			default:
			begin
				nxt_s.st   = ST_SLEEP;
				nxt_s.ramp = REF_ZERO;
			end
		endcase

		awake = (s_ff.st != ST_SLEEP);
		sw_en = awake && !HICCUP_I && gate;

		// Reference caps the demand during soft-start
		demand_eff = (DEMAND_I < s_ff.ramp) ? DEMAND_I : s_ff.ramp;
		hit = (SENSE_I >= demand_eff);

		// Set wins at cycle start; the compare ends the on-time later
		if (osc_tick)
			nxt_s.latch = 1'b1;
		else if (hit)
			nxt_s.latch = 1'b0;

		nxt_s.sw_gate   = nxt_s.latch && sw_en;
		nxt_s.load_on   = awake && !HICCUP_I && gate;
		nxt_s.comp_hold = !gate;
		nxt_s.sleep     = (nxt_s.st == ST_SLEEP);
	end

	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			s_ff       <= '0;
			s_ff.st    <= ST_SLEEP;
			s_ff.sleep <= 1'b1;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign SWITCH_GATE_DRIVE_O = s_ff.sw_gate;
	assign LOAD_SWITCH_DRIVE_O = s_ff.load_on;
	assign COMP_HOLD_O         = s_ff.comp_hold;
	assign SLEEP_O             = s_ff.sleep;
	assign CURRENT_REFERENCE_O = s_ff.ramp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence dim_low_run_s;
		!dim_hi && awake;
	endsequence

	sequence wake_s;
		(s_ff.st == ST_SLEEP) && dim_hi;
	endsequence

	latch_set_a: assert property (osc_tick |=> s_ff.latch)
		else $error("latch not set at cycle start");

	gate_on_a: assert property (osc_tick && sw_en |=> SWITCH_GATE_DRIVE_O)
		else $error("gate not on at cycle start");

	latch_reset_a: assert property (!osc_tick && hit |=> !s_ff.latch && !SWITCH_GATE_DRIVE_O)
		else $error("latch not reset on current hit");

	load_off_a: assert property (!dim_hi |=> !LOAD_SWITCH_DRIVE_O)
		else $error("load switch on while dim low");

	comp_hold_a: assert property (dim_low_run_s |=> COMP_HOLD_O && !SWITCH_GATE_DRIVE_O)
		else $error("no hold while dim low");

	restore_a: assert property (dim_hi && awake && !int_act && !HICCUP_I
		|=> !COMP_HOLD_O && LOAD_SWITCH_DRIVE_O)
		else $error("drive not restored while dim high");

	ext_override_a: assert property (ext_seen && dim_hi && awake && !HICCUP_I
		|=> LOAD_SWITCH_DRIVE_O)
		else $error("internal pwm not overridden");

	int_gate_a: assert property (int_act && !pwm_on |=> !LOAD_SWITCH_DRIVE_O && COMP_HOLD_O)
		else $error("internal pwm off phase not gated");

	sleep_entry_a: assert property (dim_low_run_s ##0 us_tick
		##0 (s_ff.dis_cnt >= dis_lim - CNT_ONE) |=> SLEEP_O)
		else $error("sleep not entered at disable time");

	dis_limit_a: assert property (awake && !dim_hi |-> s_ff.dis_cnt < dis_lim)
		else $error("disable timer past limit while awake");

	soft_start_a: assert property (wake_s |=> (s_ff.st == ST_SOFT) && (s_ff.ramp == REF_ZERO)
		##1 (s_ff.ramp <= REF_STEP))
		else $error("soft start not begun from zero");

	hiccup_ref_a: assert property (awake && HICCUP_I && dim_hi |=> s_ff.ramp == REF_ZERO)
		else $error("reference not cleared in hiccup");

	timer_clear_a: assert property (dim_hi |=> s_ff.dis_cnt == CNT_ZERO)
		else $error("sleep timer not cleared");

	latch_stay_a: assert property (!s_ff.latch && !osc_tick |=> !s_ff.latch)
		else $error("latch set between cycle starts");

	ext_mark_a: assert property (dim_edge |=> ext_seen)
		else $error("external dimming edge not marked");

	sleep_off_a: assert property (!awake |=> !s_ff.sw_gate && !s_ff.load_on)
		else $error("drives on while asleep");

	run_ref_a: assert property ((s_ff.st == ST_RUN) |-> (s_ff.ramp == REF_ONE_VOLT))
		else $error("reference below full scale in run");

endmodule : ldgs_top

`default_nettype wire

// ==== dv/ldgs_dim_src.sv ====
/*
 Model of the party driving the dim-control pin: static level or PWM.
 Assumes the bench clock; the pin only changes on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module ldgs_dim_src (
	// Clock
	input  wire logic       clk_i,
	// Control
	input  wire logic       pwm_en_i,
	input  wire logic       level_i,
	input  wire logic [7:0] hi_cyc_i,
	input  wire logic [7:0] per_cyc_i,
	// Pin
	output logic            pin_o
);
	logic [7:0] ph_ff = 8'h00;

	// Float is modelled as a high level
	always @(negedge clk_i)
	begin
		ph_ff <= (ph_ff + 8'h01 >= per_cyc_i) ? 8'h00 : ph_ff + 8'h01;
		pin_o <= pwm_en_i ? (ph_ff < hi_cyc_i) : level_i;
	end
endmodule : ldgs_dim_src

`default_nettype wire

// ==== dv/ldgs_top_tb.sv ====
/*
 Self-checking bench for the dimming gate and sleep control.
 Assumes shortened time parameters; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module ldgs_top_tb;
	import ldgs_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	wire logic  dim;
	logic [7:0] duty = 8'hFF;
	logic [9:0] sense = 10'h000;
	logic [9:0] demand = 10'h3FF;
	logic       hic = 1'b0;
	logic       gate, load, hold, slp;
	logic [9:0] ref_o;
	logic       p_pwm = 1'b0;
	logic       p_lvl = 1'b1;
	logic [7:0] p_hi = 8'h14;
	logic [7:0] p_per = 8'h28;
	int         fail_count = 0;
	int         total_checks = 0;

	always #25 clk = ~clk;

	ldgs_dim_src SRC (.clk_i(clk), .pwm_en_i(p_pwm), .level_i(p_lvl),
		.hi_cyc_i(p_hi), .per_cyc_i(p_per), .pin_o(dim));

	// Short times keep the run small
	ldgs_top #(.P_INT_DIS_US(20), .P_EXT_DIS_US(40), .P_EXT_SEEN_US(10),
		.P_US_CYC(2), .P_PWM_STEP_US(1)) DUT (
		.MCLK_I(clk), .SYS_RST_I(rst), .DIM_CONTROL_INPUT_I(dim),
		.DUTY_SET_INPUT_I(duty), .SENSE_I(sense), .DEMAND_I(demand),
		.HICCUP_I(hic), .SWITCH_GATE_DRIVE_O(gate), .LOAD_SWITCH_DRIVE_O(load),
		.COMP_HOLD_O(hold), .SLEEP_O(slp), .CURRENT_REFERENCE_O(ref_o));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task count_hi(input int n, output int c, output int d);
		c = 0;
		d = 0;
		repeat (n)
		begin
			cyc(1);
			c += (gate === 1'b1) ? 1 : 0;
			d += (hold === load) ? 1 : 0;
		end
	endtask : count_hi

	task ref_full;
		int i;
		for (i = 0; i < 2200 && ref_o !== 10'h3FF; i++)
			cyc(1);
		check(ref_o, 10'h3FF);
	endtask : ref_full

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_wake;
		check(slp, 1'b1);
		cyc(5);
		check(slp, 1'b0);
		check(ref_o < 10'h010, 1'b1);
		cyc(1000);
		check(ref_o < 10'h3FF, 1'b1);
		ref_full();
	endtask : t_wake

	task t_dim;
		p_lvl <= 1'b0;
		cyc(4);
		check(load, 1'b0);
		check({gate, hold}, 2'b01);
		cyc(30);
		p_lvl <= 1'b1;
		cyc(4);
		check({load, hold}, 2'b10);
		cyc(60);
		check(gate, 1'b1);
		// Lows just under the limit must not add up to sleep
		repeat (3)
		begin
			p_lvl <= 1'b0;
			cyc(60);
			p_lvl <= 1'b1;
			cyc(10);
		end
		check(slp, 1'b0);
	endtask : t_dim

	task t_latch;
		int c, d;
		sense <= 10'h0FF;
		demand <= 10'h100;
		count_hi(570, c, d);
		check(c >= 560, 1'b1);
		sense <= 10'h100;
		cyc(3);
		count_hi(570, c, d);
		check(c >= 9 && c <= 11, 1'b1);
		sense <= 10'h000;
		demand <= 10'h3FF;
	endtask : t_latch

	task t_ext;
		int c, d;
		duty <= 8'h00;
		p_pwm <= 1'b1;
		cyc(200);
		c = 0;
		repeat (400)
		begin
			cyc(1);
			c += (load === 1'b1) ? 1 : 0;
		end
		check(c >= 185 && c <= 215, 1'b1);
		check(slp, 1'b0);
		p_pwm <= 1'b0;
	endtask : t_ext

	task t_int;
		int c, d;
		duty <= 8'h80;
		cyc(100);
		c = 0;
		d = 0;
		repeat (1024)
		begin
			cyc(1);
			c += (load === 1'b1) ? 1 : 0;
			d += (hold === load) ? 1 : 0;
		end
		check(c >= 504 && c <= 520, 1'b1);
		check(d == 0, 1'b1);
		duty <= 8'hFF;
	endtask : t_int

	task t_sleep(input logic [7:0] d, input int lim);
		// Let the duty written by the previous scenario settle first
		cyc(1);
		duty <= d;
		cyc(2);
		p_lvl <= 1'b0;
		cyc(lim * 2 - 4);
		check(slp, 1'b0);
		cyc(10);
		check(slp, 1'b1);
		p_lvl <= 1'b1;
		cyc(5);
		check(slp, 1'b0);
		check(ref_o < 10'h008, 1'b1);
		ref_full();
	endtask : t_sleep

	task t_hiccup;
		hic <= 1'b1;
		cyc(4);
		check(ref_o, 10'h000);
		check({gate, load}, 2'b00);
		hic <= 1'b0;
		cyc(4);
		check(ref_o < 10'h008, 1'b1);
		ref_full();
	endtask : t_hiccup

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		cyc(6);
		rst <= 1'b0;
		t_wake();
		t_dim();
		t_latch();
		t_ext();
		t_int();
		t_sleep(8'h80, 20);
		t_sleep(8'hFF, 40);
		t_hiccup();
		give_verdict();
	end

	initial
	begin
		#(50 * 40000);
		fail_count++;
		give_verdict();
	end
endmodule : ldgs_top_tb

`default_nettype wire
